// ---- design/watchdog_timeout_reset.sv ----
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps

// Contract
// R1 - 12-bit prescaler overflow feeds 6-bit counter
// R2 - timing only from crystal clock
// R3 - overflow resets after short or long count
// R4 - service write clears counter, prescaler stages 12-5
// R5 - service read returns vector low byte
// R6 - reset pin low 32 crystal cycles, cause flag
// R7 - stop instruction clears whole prescaler
// R8 - internal reset clears prescaler and counter
// R9 - reset vector fetch clears prescaler
// R10 - disable option suppresses watchdog resets
// R11 - monitor mode test level disables watchdog
// R12 - break state reset-pin test level disables
// R13 - never raises a processor interrupt request
// R14 - keeps counting during wait mode
// R15 - stop mode gates crystal, clears prescaler
// R16 - stop option zero blocks stop instruction
// R17 - software services from main program loop
// R18 - software services around stop mode
module watchdog_timeout_reset #(
    parameter int         PRE_W           = watchdog_pkg::PRESCALE_W,
    parameter int         CNT_W           = watchdog_pkg::WD_W,
    parameter int         LOW_CYCLES      = watchdog_pkg::PIN_LOW_CYCLES,
    parameter logic [7:0] RESET_VECTOR_LO = watchdog_pkg::RESET_VECTOR_LO_DEFAULT
) (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // wishbone slave
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [watchdog_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    // crystal clock level, sampled on clk_i
    input  wire logic                           crystal_clock_i,
    // system events
    input  wire logic                           internal_reset_i,
    input  wire logic                           vector_fetch_i,
    input  wire logic                           stop_mode_i,
    input  wire logic                           wait_mode_i,
    // test conditions
    input  wire logic                           monitor_mode_i,
    input  wire logic                           break_state_i,
    input  wire logic                           irq_test_level_i,
    input  wire logic                           rst_test_level_i,
    // reset outputs
    output logic                                watchdog_reset_o,
    output logic                                rst_pin_o,
    output logic                                rst_pin_oe_o,
    output logic                                stop_allowed_o,
    // status notification
    output logic                                status_alert_o
);

    initial begin
        if (PRE_W != watchdog_pkg::PRESCALE_W || CNT_W != watchdog_pkg::WD_W) begin
            $error("watchdog_timeout_reset: counter widths are fixed");
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire                          req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [watchdog_pkg::IDX_W-1:0] idx       = wb_adr_i[watchdog_pkg::ADR_W-1:2];
    wire                          wr         = req & wb_we_i;
    wire                          rd         = req & ~wb_we_i;
    wire                          lane0      = wb_sel_i[0];
    wire                          hit_svc    = idx == watchdog_pkg::IDX_SERVICE;
    wire                          hit_opt    = idx == watchdog_pkg::IDX_OPTION;
    wire                          hit_stat   = idx == watchdog_pkg::IDX_STATUS;
    wire                          hit_mask   = idx == watchdog_pkg::IDX_MASK;
    wire                          hit_cnt    = idx == watchdog_pkg::IDX_COUNT;
    wire                          svc_write  = wr & hit_svc & (|wb_sel_i); // R4
    wire                          opt_write  = wr & hit_opt & lane0;
    wire                          mask_write = wr & hit_mask & lane0;
    wire                          stat_read  = rd & hit_stat;

    // ------------------------------------------------------------
    // software state
    // ------------------------------------------------------------
    logic [watchdog_pkg::OPT_W-1:0]  opt_r;
    logic [watchdog_pkg::STAT_W-1:0] stat_r;
    logic [watchdog_pkg::STAT_W-1:0] stat_nxt;
    logic [watchdog_pkg::STAT_W-1:0] mask_r;
    logic                            ack_r;
    logic [31:0]                     dat_r;
    logic [31:0]                     dat_nxt;

    wire short_sel   = opt_r[watchdog_pkg::OPT_SHORT];
    wire disable_opt = opt_r[watchdog_pkg::OPT_DISABLE];
    wire stop_enable = opt_r[watchdog_pkg::OPT_STOP_EN];

    // ------------------------------------------------------------
    // crystal clock edge and gating
    // ------------------------------------------------------------
    logic crystal_prev_r;
    wire  stop_active = stop_mode_i & stop_enable; // R16
    wire  crystal_edge = crystal_clock_i & ~crystal_prev_r;
    // wait mode does not gate the tick
    wire  tick = crystal_edge & ~stop_active; // R2 R14 R15

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crystal_prev_r <= 1'b0;
        end else begin
            crystal_prev_r <= crystal_clock_i;
        end
    end

    // ------------------------------------------------------------
    // disable conditions
    // ------------------------------------------------------------
    wire mon_off = monitor_mode_i & (irq_test_level_i | rst_test_level_i); // R11
    wire brk_off = break_state_i & rst_test_level_i; // R12
    wire held_off = mon_off | brk_off;

    // ------------------------------------------------------------
    // counter chain and clears
    // ------------------------------------------------------------
    logic [PRE_W-1:0] pre_w;
    logic [CNT_W-1:0] cnt_w;
    logic             overflow;
    logic             pin_active;

    wire clr_counters = internal_reset_i | pin_active | held_off; // R8
    wire clr_pre_only = stop_active | vector_fetch_i; // R7 R9 R15
    wire clr_all      = clr_counters | clr_pre_only;

    // stop clears the prescaler only, the counter keeps its value
    logic [CNT_W-1:0] unused_cnt;
    assign unused_cnt = cnt_w;

    watchdog_counter_chain #(
        .PRE_W (PRE_W),
        .CNT_W (CNT_W)
    ) u_chain (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .tick_i        (tick),
        .clr_all_i     (clr_counters),
        .clr_service_i (svc_write),
        .clr_pre_i     (clr_pre_only),
        .short_i       (short_sel),
        .pre_o         (pre_w),
        .cnt_o         (cnt_w),
        .timeout_o     (overflow)
    );

    // ------------------------------------------------------------
    // prescaler-only clear on stop and vector fetch
    // ------------------------------------------------------------
    // registered record of a prescaler-only clear
    logic pre_full_clr_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_full_clr_r <= 1'b0;
        end else begin
            pre_full_clr_r <= clr_pre_only;
        end
    end

    // ------------------------------------------------------------
    // timeout to reset
    // ------------------------------------------------------------
    wire fire = overflow & ~disable_opt & ~held_off & ~clr_all; // R3 R10

    watchdog_reset_stretcher #(
        .LOW_CYCLES (LOW_CYCLES)
    ) u_stretch (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (fire),
        .tick_i   (crystal_edge),
        .active_o (pin_active)
    );

    // on timeout a reset leaves the block, plus status_alert_o when mask bit 0 is set, never a cpu request
    assign watchdog_reset_o = pin_active; // R13
    assign rst_pin_o        = 1'b0; // R6
    assign rst_pin_oe_o     = pin_active; // R6
    assign stop_allowed_o   = stop_enable; // R16

    // ------------------------------------------------------------
    // option and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_r <= watchdog_pkg::OPT_RESET;
        end else if (opt_write) begin
            opt_r <= wb_dat_i[watchdog_pkg::OPT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= watchdog_pkg::MASK_RESET;
        end else if (mask_write) begin
            mask_r <= wb_dat_i[watchdog_pkg::STAT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // sticky status, cleared by read, set wins
    // ------------------------------------------------------------
    always_comb begin
        stat_nxt = stat_read ? '0 : stat_r;
        if (fire) begin
            stat_nxt[watchdog_pkg::ST_WD_CAUSE] = 1'b1; // R6
        end
        if (svc_write) begin
            stat_nxt[watchdog_pkg::ST_SERVICED] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= watchdog_pkg::STAT_RESET;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign status_alert_o = |(stat_r & mask_r);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        dat_nxt = '0;
        if (hit_svc) begin
            dat_nxt[7:0] = RESET_VECTOR_LO; // R5
        end else if (hit_opt) begin
            dat_nxt[watchdog_pkg::OPT_W-1:0] = opt_r;
        end else if (hit_stat) begin
            dat_nxt[watchdog_pkg::STAT_W-1:0] = stat_r;
        end else if (hit_mask) begin
            dat_nxt[watchdog_pkg::STAT_W-1:0] = mask_r;
        end else if (hit_cnt) begin
            dat_nxt[PRE_W+CNT_W-1:0] = {cnt_w, pre_w};
        end
    end

    // ------------------------------------------------------------
    // acknowledge, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= req;
            if (rd) begin
                dat_r <= dat_nxt;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    logic unused_ok;
    assign unused_ok = wait_mode_i & pre_full_clr_r & (|unused_cnt);

endmodule // watchdog_timeout_reset

// ---- design/watchdog_pkg.sv ----
package watchdog_pkg;

    // ------------------------------------------------------------
    // counter chain
    // ------------------------------------------------------------
    localparam int PRESCALE_W = 12;
    localparam int WD_W       = 6;
    localparam int SVC_CLR_LO = 4;
    localparam int SVC_CLR_HI = 11;
    localparam int PIN_LOW_CYCLES = 32;
    localparam int PIN_CNT_W  = 6;

    // ------------------------------------------------------------
    // bus map (word index, byte address is four times it)
    // ------------------------------------------------------------
    localparam int ADR_W = 18;
    localparam int IDX_W = 16;
    localparam logic [IDX_W-1:0] IDX_SERVICE = 16'hFFFF;
    localparam logic [IDX_W-1:0] IDX_OPTION  = 16'h001F;
    localparam logic [IDX_W-1:0] IDX_STATUS  = 16'h0020;
    localparam logic [IDX_W-1:0] IDX_MASK    = 16'h0021;
    localparam logic [IDX_W-1:0] IDX_COUNT   = 16'h0022;

    // ------------------------------------------------------------
    // option register fields
    // ------------------------------------------------------------
    localparam int OPT_W        = 3;
    localparam int OPT_SHORT    = 0;
    localparam int OPT_DISABLE  = 1;
    localparam int OPT_STOP_EN  = 2;
    localparam logic [OPT_W-1:0] OPT_RESET = 3'h0;

    // ------------------------------------------------------------
    // status and mask fields
    // ------------------------------------------------------------
    localparam int STAT_W       = 2;
    localparam int ST_WD_CAUSE  = 0;
    localparam int ST_SERVICED  = 1;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
    localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;

    localparam logic [7:0] RESET_VECTOR_LO_DEFAULT = 8'h00;

endpackage

// ---- design/watchdog_counter_chain.sv ----
`timescale 1ns/1ps

module watchdog_counter_chain #(
    parameter int PRE_W = watchdog_pkg::PRESCALE_W,
    parameter int CNT_W = watchdog_pkg::WD_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             tick_i,
    input  wire logic             clr_all_i,
    input  wire logic             clr_service_i,
    input  wire logic             clr_pre_i,
    input  wire logic             short_i,
    // state
    output logic [PRE_W-1:0]      pre_o,
    output logic [CNT_W-1:0]      cnt_o,
    output logic                  timeout_o
);

    initial begin
        if (PRE_W <= watchdog_pkg::SVC_CLR_HI || CNT_W < 2) begin
            $error("watchdog_counter_chain: unsupported widths");
        end
    end

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [PRE_W-1:0] svc_mask;
    wire              pre_wrap = tick_i & (&pre_r);

    // clear stages 12 down to 5 on service
    always_comb begin
        svc_mask = '1;
        svc_mask[watchdog_pkg::SVC_CLR_HI:watchdog_pkg::SVC_CLR_LO] = '0; // R4
    end

    always_comb begin
        pre_nxt = tick_i ? pre_r + {{(PRE_W-1){1'b0}}, 1'b1} : pre_r; // R1
        cnt_nxt = pre_wrap ? cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_r; // R1
        if (clr_service_i) begin
            pre_nxt = pre_r & svc_mask; // R4
            cnt_nxt = '0; // R4
        end
        if (clr_pre_i) begin
            pre_nxt = '0; // R7 R9
            cnt_nxt = cnt_r;
        end
        if (clr_all_i) begin
            pre_nxt = '0; // R8
            cnt_nxt = '0; // R8
        end
    end

    // short tap at two watchdog steps, long at full overflow
    assign timeout_o = pre_wrap & ~clr_service_i & ~clr_all_i & ~clr_pre_i &
                       (short_i ? cnt_r[0] : (&cnt_r)); // R3

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= '0;
            cnt_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign pre_o = pre_r;
    assign cnt_o = cnt_r;

endmodule // watchdog_counter_chain

// ---- design/watchdog_reset_stretcher.sv ----
`timescale 1ns/1ps

module watchdog_reset_stretcher #(
    parameter int LOW_CYCLES = watchdog_pkg::PIN_LOW_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic start_i,
    input  wire logic tick_i,
    // state
    output logic      active_o
);

    initial begin
        if (LOW_CYCLES < 1 || LOW_CYCLES >= (1 << watchdog_pkg::PIN_CNT_W)) begin
            $error("watchdog_reset_stretcher: unsupported length");
        end
    end

    localparam logic [watchdog_pkg::PIN_CNT_W-1:0] LAST =
        watchdog_pkg::PIN_CNT_W'(LOW_CYCLES);

    logic [watchdog_pkg::PIN_CNT_W-1:0] cnt_r;
    logic                               active_r;

    // ------------------------------------------------------------
    // hold the pin low for the fixed number of crystal cycles
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r    <= '0;
            active_r <= 1'b0;
        end else if (start_i && !active_r) begin
            cnt_r    <= '0;
            active_r <= 1'b1;
        end else if (active_r && tick_i) begin
            cnt_r    <= cnt_r + 1'b1;
            active_r <= (cnt_r + 1'b1) != LAST; // R6
        end
    end

    assign active_o = active_r;

endmodule // watchdog_reset_stretcher

// ---- test/watchdog_timeout_reset_checker.sv ----
`timescale 1ns/1ps

module watchdog_timeout_reset_checker #(
    parameter logic [7:0] RESET_VECTOR_LO = watchdog_pkg::RESET_VECTOR_LO_DEFAULT
) (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // wishbone
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [watchdog_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    input  wire logic [31:0]                    wb_dat_o,
    input  wire logic                           wb_ack_o,
    // test conditions
    input  wire logic                           monitor_mode_i,
    input  wire logic                           break_state_i,
    input  wire logic                           irq_test_level_i,
    input  wire logic                           rst_test_level_i,
    // reset outputs
    input  wire logic                           watchdog_reset_o,
    input  wire logic                           rst_pin_o,
    input  wire logic                           rst_pin_oe_o,
    input  wire logic                           stop_allowed_o
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [watchdog_pkg::OPT_W-1:0] opt_r;
    wire  [watchdog_pkg::IDX_W-1:0] idx     = wb_adr_i[watchdog_pkg::ADR_W-1:2];
    wire                            taken   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire                            opt_wr  = taken && wb_we_i && wb_sel_i[0]
                                              && idx == watchdog_pkg::IDX_OPTION;
    wire                            svc_rd  = taken && !wb_we_i && idx == watchdog_pkg::IDX_SERVICE;
    wire                            mon_off = monitor_mode_i && (irq_test_level_i || rst_test_level_i);
    wire                            brk_off = break_state_i && rst_test_level_i;
    wire                            wd_off  = opt_r[watchdog_pkg::OPT_DISABLE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_r <= watchdog_pkg::OPT_RESET;
        end else if (opt_wr) begin
            opt_r <= wb_dat_i[watchdog_pkg::OPT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_twice(c);
        c ##1 c;
    endsequence
    sequence s_rst_rise;
        $rose(watchdog_reset_o);
    endsequence

    a_ack_answers: assert property (taken |=> wb_ack_o) else $error("no ack after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_service_read: assert property (svc_rd |=> wb_dat_o[7:0] == RESET_VECTOR_LO)
        else $error("service read data wrong");
    a_stop_follows: assert property (opt_wr |-> ##2 stop_allowed_o == opt_r[watchdog_pkg::OPT_STOP_EN])
        else $error("stop permission not following option");
    a_pin_pulls_low: assert property (rst_pin_oe_o |-> !rst_pin_o)
        else $error("reset pin driven high");
    a_pin_tracks_reset: assert property (rst_pin_oe_o == watchdog_reset_o)
        else $error("pin enable differs from reset");
    a_pulse_min_width: assert property (s_rst_rise |-> watchdog_reset_o[*8])
        else $error("reset pulse too short");
    a_disable_blocks: assert property (s_twice(wd_off) |-> !$rose(watchdog_reset_o))
        else $error("reset while disabled");
    a_monitor_blocks: assert property (s_twice(mon_off) |-> !$rose(watchdog_reset_o))
        else $error("reset in monitor test level");
    a_break_blocks: assert property (s_twice(brk_off) |-> !$rose(watchdog_reset_o))
        else $error("reset in break test level");
endmodule // watchdog_timeout_reset_checker

bind watchdog_timeout_reset watchdog_timeout_reset_checker #(
    .RESET_VECTOR_LO(RESET_VECTOR_LO)
) i_watchdog_timeout_reset_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .monitor_mode_i(monitor_mode_i),
    .break_state_i(break_state_i), .irq_test_level_i(irq_test_level_i),
    .rst_test_level_i(rst_test_level_i), .watchdog_reset_o(watchdog_reset_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .stop_allowed_o(stop_allowed_o)
);

// ---- test/test_watchdog_timeout_reset.sv ----
`timescale 1ns/1ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

module test_watchdog_timeout_reset;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [17:0] wb_adr_i = 18'h00000;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
    logic        wb_ack_o, crystal_clock_i = 1'b0, int_rst = 1'b0, vfetch = 1'b0;
    logic        stop_mode = 1'b0, wait_mode = 1'b0, xtal_en = 1'b0, saw_rst = 1'b0;
    logic [3:0]  tst = 4'h0;
    logic [1:0]  ph = 2'h0;
    logic        watchdog_reset_o, rst_pin_o, rst_pin_oe_o, stop_allowed_o, status_alert_o;
    int          ticks = 0, errors = 0, num_checks = 0, base;
    logic [15:0] idx_tab [5] = '{16'h001F, 16'h0020, 16'h0021, 16'h0022, 16'h0100};
    logic [3:0]  tst_tab [5] = '{4'hA, 4'h9, 4'h5, 4'h6, 4'h8};
    logic [17:0] exp_tab [5] = '{18'h0, 18'h0, 18'h0, 18'hA, 18'hA};

    watchdog_timeout_reset #(.RESET_VECTOR_LO(8'hA5)) i_watchdog_timeout_reset (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_clock_i(crystal_clock_i),
        .internal_reset_i(int_rst), .vector_fetch_i(vfetch), .stop_mode_i(stop_mode),
        .wait_mode_i(wait_mode), .monitor_mode_i(tst[3]), .break_state_i(tst[2]),
        .irq_test_level_i(tst[1]), .rst_test_level_i(tst[0]),
        .watchdog_reset_o(watchdog_reset_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
        .stop_allowed_o(stop_allowed_o), .status_alert_o(status_alert_o));

    // ------------------------------------------------------------
    // clock and crystal ticks (one rise every three clocks)
    // ------------------------------------------------------------
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (xtal_en) begin
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            crystal_clock_i <= (ph == 2'h0);
            if (ph == 2'h0) ticks <= ticks + 1;
        end else begin
            ph <= 2'h0;
            crystal_clock_i <= 1'b0;
        end
        if (watchdog_reset_o === 1'b1) saw_rst <= 1'b1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic xfer(input logic we, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) begin errors++; wrap_up(); end
    endtask
    task automatic count_is(input logic [17:0] exp);
        xfer(1'b0, watchdog_pkg::IDX_COUNT, 32'h0);
        `CHK(rd[17:0], exp)
    endtask
    task automatic run_ticks(input int n);
        int target;
        target = ticks + n;
        xtal_en <= 1'b1;
        for (int i = 0; i < 4 * n + 10 && ticks < target; i++) @(posedge clk_i);
        xtal_en <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic clear_all();
        int_rst <= 1'b1;
        @(posedge clk_i);
        int_rst <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        xfer(1'b1, 16'h0100, 32'hFFFFFFFF);
        foreach (idx_tab[i]) begin
            xfer(1'b0, idx_tab[i], 32'h0);
            `CHK(rd, 32'h00000000)
        end
        `CHK(stop_allowed_o, 1'b0)
        $display("test reset done");
        wait_mode <= 1'b1;
        run_ticks(100);
        count_is(18'd100);
        wait_mode <= 1'b0;
        repeat (20) @(posedge clk_i);
        count_is(18'd100);
        xfer(1'b0, watchdog_pkg::IDX_SERVICE, 32'h0);
        `CHK(rd[7:0], 8'hA5)
        count_is(18'd100);
        xfer(1'b1, watchdog_pkg::IDX_MASK, 32'h2);
        xfer(1'b1, watchdog_pkg::IDX_SERVICE, 32'h5A5A5A5A);
        count_is(18'd4);
        `CHK(status_alert_o, 1'b1)
        xfer(1'b0, watchdog_pkg::IDX_STATUS, 32'h0);
        `CHK(rd[1:0], 2'b10)
        `CHK(status_alert_o, 1'b0)
        $display("test service done");
        xfer(1'b1, watchdog_pkg::IDX_SERVICE, 32'h0);
        stop_mode <= 1'b1;
        run_ticks(20);
        count_is(18'd24);
        xfer(1'b1, watchdog_pkg::IDX_OPTION, 32'h4);
        @(posedge clk_i);
        `CHK(stop_allowed_o, 1'b1)
        run_ticks(20);
        count_is(18'h00000);
        stop_mode <= 1'b0;
        xfer(1'b1, watchdog_pkg::IDX_OPTION, 32'h0);
        run_ticks(4104);
        count_is(18'h01008);
        vfetch <= 1'b1;
        @(posedge clk_i);
        vfetch <= 1'b0;
        count_is(18'h01000);
        clear_all();
        count_is(18'h00000);
        $display("test clears done");
        foreach (tst_tab[i]) begin
            tst <= tst_tab[i];
            run_ticks(10);
            count_is(exp_tab[i]);
            tst <= 4'h0;
            clear_all();
        end
        $display("test test levels done");
        xfer(1'b1, watchdog_pkg::IDX_MASK, 32'h1);
        xfer(1'b1, watchdog_pkg::IDX_OPTION, 32'h1);
        clear_all();
        base = ticks;
        xtal_en <= 1'b1;
        for (int i = 0; i < 30000 && watchdog_reset_o !== 1'b1; i++) @(posedge clk_i);
        if (watchdog_reset_o !== 1'b1) begin errors++; wrap_up(); end
        `CHK(ticks - base >= 8192 && ticks - base <= 8194, 1'b1)
        `CHK(rst_pin_oe_o, 1'b1)
        `CHK(rst_pin_o, 1'b0)
        base = ticks;
        for (int i = 0; i < 300 && watchdog_reset_o === 1'b1; i++) @(posedge clk_i);
        `CHK(ticks - base >= 31 && ticks - base <= 33, 1'b1)
        xtal_en <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(status_alert_o, 1'b1)
        xfer(1'b0, watchdog_pkg::IDX_STATUS, 32'h0);
        `CHK(rd[0], 1'b1)
        `CHK(status_alert_o, 1'b0)
        $display("test timeout done");
        xfer(1'b1, watchdog_pkg::IDX_OPTION, 32'h3);
        clear_all();
        saw_rst <= 1'b0;
        run_ticks(8300);
        `CHK(saw_rst, 1'b0)
        xfer(1'b0, watchdog_pkg::IDX_STATUS, 32'h0);
        `CHK(rd[0], 1'b0)
        $display("test disable done");
        wrap_up();
    end
endmodule // test_watchdog_timeout_reset
